/* File: verilog/ses_defines.vh */
// What this block does
// - Jump-count query gives jumps done in selected step, -1 when idle.
// - Current-step query gives executing step 1..255, -1 when idle.
// - Control codes: 0 stop, 1 start, 2 hold, 3 branch 0, 4 branch 1.
// - Memory command code 0 clears the whole stored sequence program.
// - First parameter is the signed DC level, voltage or current units.
// - DC, AC and frequency operation: 0 constant, 1 keep, 2 sweep.
// - Third parameter is the AC amplitude, voltage or current units.
// - Fifth parameter is frequency, 1.0 to 100000.0 Hz in 0.1 Hz.
// - Waveform codes 2 to 17 select user waveforms one to sixteen.
// - Waveform and sync operations allow only constant and keep.
// - Sync code 0..3 drives the two sync bits as its binary value.
// - Sequence length query always reads 255.
// - State query reads 0 idle, 1 running, 2 holding.
// - Step time is counted in whole seconds.
// - Step may also wait for waveform phase zero before ending.
// - Termination: 0 continue, 1 go idle, 2 go hold.
// - Jump target 0 means next step, 1..255 jumps there.
// - Jump count 0 unlimited, 1..999 exact number of jumps.
// - Branch-0 target 0 disables, else destination on branch 0.
// - Branch-1 target 0 disables, else destination on branch 1.
`ifndef SES_DEFINES_VH
`define SES_DEFINES_VH
`define SES_A_CTRL   8'h00
`define SES_A_MEM    8'h04
`define SES_A_SEL    8'h08
`define SES_A_EXP0   8'h0c
`define SES_A_TRP2   8'h24
`define SES_A_STAT   8'h28
`define SES_A_CUR    8'h2c
`define SES_A_JCNT   8'h30
`define SES_A_LEN    8'h34
`define SES_F_VAL    19:0
`define SES_F_OP     21:20
`define SES_F_WAVE   4:0
`define SES_F_WOP    8
`define SES_F_SYNC   13:12
`define SES_F_SOP    16
`define SES_F_TIME   15:0
`define SES_F_PHEN   0
`define SES_F_TERM   5:4
`define SES_F_JMP    15:8
`define SES_F_JCNT   25:16
`define SES_F_BR0    7:0
`define SES_F_BR1    15:8
`define SES_ST_IDLE  2'd0
`define SES_ST_RUN   2'd1
`define SES_ST_HOLD  2'd2
`define SES_C_STOP   3'd0
`define SES_C_START  3'd1
`define SES_C_HOLD   3'd2
`define SES_C_BR0    3'd3
`define SES_C_BR1    3'd4
`define SES_OP_CONST 2'd0
`define SES_OP_KEEP  2'd1
`define SES_OP_SWEEP 2'd2
`define SES_T_CONT   2'd0
`define SES_T_IDLE   2'd1
`define SES_T_HOLD   2'd2
`define SES_SEQ_LEN  32'h000000ff
`define SES_NONE     32'hffffffff
`define SES_UNIT_NS  1000000000
`define SES_CLK_NS   5
`define SES_UNIT_CYC (`SES_UNIT_NS / `SES_CLK_NS)
`define SES_SWEEP_CYC 2000
`define SES_WORDS    7
`endif

/* File: verilog/ses_step_mem.v */
`timescale 1ns/1ps
`include "ses_defines.vh"
module ses_step_mem (
  // Clock and reset
  input  wire          sys_clk,
  input  wire          resetn,
  // Host write and clear
  input  wire          clr,
  input  wire          we,
  input  wire [7:0]    wr_step,
  input  wire [2:0]    wr_word,
  input  wire [31:0]   wr_data,
  // Host read
  input  wire [7:0]    rd_step,
  input  wire [2:0]    rd_word,
  output wire [31:0]   rd_data,
  // Sequencer read, all words of one step
  input  wire [7:0]    run_step,
  output wire [223:0]  run_data
);
  wire [31:0] rd_w [0:7];
  genvar w;
  generate
    for (w = 0; w < `SES_WORDS; w = w + 1)
    begin : g_word
      reg [31:0] mem [0:255];
      integer i;
      always @(posedge sys_clk or negedge resetn)
      begin
        if (!resetn)
        begin
          for (i = 0; i < 256; i = i + 1)
            mem[i] <= 32'h00000000;
        end
        else if (clr)
        begin
          for (i = 0; i < 256; i = i + 1)
            mem[i] <= 32'h00000000;
        end
        else if (we && wr_word == w)
          mem[wr_step] <= wr_data;
      end
      assign rd_w[w] = mem[rd_step];
      assign run_data[w*32 +: 32] = mem[run_step];
    end
  endgenerate
  assign rd_w[7] = 32'h00000000;
  assign rd_data = rd_w[rd_word];
endmodule // ses_step_mem

/* File: verilog/ses_top.v */
`timescale 1ns/1ps
`include "ses_defines.vh"
module ses_top #(
  parameter [31:0] UNIT_CYC  = `SES_UNIT_CYC,
  parameter [31:0] SWEEP_CYC = `SES_SWEEP_CYC
) (
  // Clock and reset
  input  wire          sys_clk,
  input  wire          resetn,
  // AXI4-Lite write address
  input  wire [7:0]    s_axi_awaddr,
  input  wire          s_axi_awvalid,
  output reg           s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0]   s_axi_wdata,
  input  wire [3:0]    s_axi_wstrb,
  input  wire          s_axi_wvalid,
  output reg           s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]    s_axi_bresp,
  output reg           s_axi_bvalid,
  input  wire          s_axi_bready,
  // AXI4-Lite read address
  input  wire [7:0]    s_axi_araddr,
  input  wire          s_axi_arvalid,
  output reg           s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0]   s_axi_rdata,
  output reg  [1:0]    s_axi_rresp,
  output reg           s_axi_rvalid,
  input  wire          s_axi_rready,
  // Waveform phase reference
  input  wire          wave_phase_zero,
  // Set-points to the output stage
  output wire [19:0]   out_dc,
  output wire [19:0]   out_ac,
  output wire [19:0]   out_freq,
  output reg  [4:0]    out_wave,
  output reg  [1:0]    out_sync,
  output reg  [1:0]    seq_state
);
  // Write channel capture
  reg  [7:0]   aw_a;
  reg          aw_have;
  reg  [31:0]  w_d;
  reg          w_full;
  reg          w_have;
  wire         wr_fire = aw_have && w_have && !s_axi_bvalid;
  wire         wr_step_reg = aw_a >= `SES_A_EXP0 && aw_a <= `SES_A_TRP2
                             && aw_a[1:0] == 2'b00;
  wire         wr_ok = wr_step_reg || aw_a == `SES_A_CTRL
                       || aw_a == `SES_A_MEM || aw_a == `SES_A_SEL;
  wire [7:0]   wr_off = aw_a - `SES_A_EXP0;
  wire [7:0]   rd_off = s_axi_araddr - `SES_A_EXP0;

  // Host-side control
  reg  [7:0]   step_select;
  reg          cmd_fire;
  reg  [2:0]   cmd_code;
  reg          mem_clr;

  // Sequencer state
  reg  [7:0]   cur;
  reg          enter;
  reg  [31:0]  tick;
  reg  [15:0]  secs;
  reg          pend_adv;
  reg  [7:0]   jmp_step;
  reg  [9:0]   jmp_done;
  reg          jmp_spent;
  reg  [31:0]  swp_cnt;
  reg  [1:0]   next_state;
  reg          next_go;
  reg  [7:0]   next_dst;
  reg          next_jmp;
  reg          next_pend;

  wire [31:0]  mem_rd;
  wire [223:0] run_data;
  wire [31:0]  w_exp3 = run_data[3*32 +: 32];
  wire [31:0]  w_trp0 = run_data[4*32 +: 32];
  wire [31:0]  w_trp1 = run_data[5*32 +: 32];
  wire [31:0]  w_trp2 = run_data[6*32 +: 32];
  wire [7:0]   jmp_t = w_trp1[`SES_F_JMP];
  wire [9:0]   jmp_n = w_trp1[`SES_F_JCNT];
  wire [7:0]   br0_t = w_trp2[`SES_F_BR0];
  wire [7:0]   br1_t = w_trp2[`SES_F_BR1];
  wire [1:0]   term = w_trp1[`SES_F_TERM];

  // Jump is taken while its budget lasts; 0 means no limit
  wire take_jump = jmp_t != 8'h00 && (jmp_n == 10'd0
                   || jmp_step != cur || jmp_spent || jmp_done < jmp_n);
  wire [7:0] seq_next = take_jump ? jmp_t : cur + 8'h01;
  wire end_seq = !take_jump && cur == 8'hff;
  wire step_done = seq_state == `SES_ST_RUN && !enter
                   && secs >= w_trp0[`SES_F_TIME]
                   && (!w_trp1[`SES_F_PHEN] || wave_phase_zero);

  ses_step_mem u_mem (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .clr      (mem_clr),
    .we       (wr_fire && wr_step_reg && w_full),
    .wr_step  (step_select),
    .wr_word  (wr_off[4:2]),
    .wr_data  (w_d),
    .rd_step  (step_select),
    .rd_word  (rd_off[4:2]),
    .rd_data  (mem_rd),
    .run_step (cur),
    .run_data (run_data)
  );

  // AXI write path: address and data taken in either order
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      aw_a <= 8'h00;
      aw_have <= 1'b0;
      w_d <= 32'h00000000;
      w_full <= 1'b0;
      w_have <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      step_select <= 8'h01;
      cmd_fire <= 1'b0;
      cmd_code <= 3'd0;
      mem_clr <= 1'b0;
    end
    else
    begin
      cmd_fire <= 1'b0;
      mem_clr <= 1'b0;
      s_axi_awready <= !aw_have && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_have && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_a <= s_axi_awaddr;
        aw_have <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_d <= s_axi_wdata;
        w_full <= s_axi_wstrb == 4'hf;
        w_have <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire)
      begin
        aw_have <= 1'b0;
        w_have <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
        // Partial-strobe writes are answered but dropped
        if (w_full && aw_a == `SES_A_CTRL && w_d[31:3] == 29'd0)
        begin
          cmd_fire <= 1'b1;
          cmd_code <= w_d[2:0];
        end
        if (w_full && aw_a == `SES_A_MEM && w_d == 32'h00000000)
          mem_clr <= 1'b1;
        if (w_full && aw_a == `SES_A_SEL && w_d[7:0] != 8'h00
            && w_d[31:8] == 24'd0)
          step_select <= w_d[7:0];
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // AXI read path, one cycle from address to data
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'b00;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'b00;
        s_axi_rdata <= 32'h00000000;
        if (s_axi_araddr >= `SES_A_EXP0 && s_axi_araddr <= `SES_A_TRP2
            && s_axi_araddr[1:0] == 2'b00)
          s_axi_rdata <= mem_rd;
        else
          case (s_axi_araddr)
            `SES_A_SEL:  s_axi_rdata <= {24'd0, step_select};
            `SES_A_STAT: s_axi_rdata <= {30'd0, seq_state};
            `SES_A_CUR:  s_axi_rdata <= seq_state == `SES_ST_IDLE ?
                                        `SES_NONE : {24'd0, cur};
            `SES_A_JCNT: s_axi_rdata <= seq_state == `SES_ST_IDLE ?
                                        `SES_NONE :
                                        (jmp_step == step_select ?
                                         {22'd0, jmp_done} : 32'd0);
            `SES_A_LEN:  s_axi_rdata <= `SES_SEQ_LEN;
            `SES_A_CTRL, `SES_A_MEM: s_axi_rdata <= 32'h00000000;
            default:     s_axi_rresp <= 2'b10;
          endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // Transition decision; a host command outranks a step ending
  always @*
  begin
    next_state = seq_state;
    next_go = 1'b0;
    next_dst = cur;
    next_jmp = 1'b0;
    next_pend = pend_adv;
    if (cmd_fire)
    begin
      case (cmd_code)
        `SES_C_STOP:
        begin
          next_state = `SES_ST_IDLE;
          next_pend = 1'b0;
        end
        `SES_C_START:
        begin
          if (seq_state == `SES_ST_IDLE)
          begin
            next_state = `SES_ST_RUN;
            next_go = 1'b1;
            next_dst = 8'h01;
          end
          else if (seq_state == `SES_ST_HOLD)
          begin
            next_state = `SES_ST_RUN;
            next_pend = 1'b0;
            if (pend_adv && end_seq)
              next_state = `SES_ST_IDLE;
            else if (pend_adv)
            begin
              next_go = 1'b1;
              next_dst = seq_next;
              next_jmp = take_jump;
            end
          end
        end
        `SES_C_HOLD:
          if (seq_state == `SES_ST_RUN)
            next_state = `SES_ST_HOLD;
        `SES_C_BR0:
          if (seq_state != `SES_ST_IDLE && br0_t != 8'h00)
          begin
            next_state = `SES_ST_RUN;
            next_go = 1'b1;
            next_dst = br0_t;
            next_pend = 1'b0;
          end
        `SES_C_BR1:
          if (seq_state != `SES_ST_IDLE && br1_t != 8'h00)
          begin
            next_state = `SES_ST_RUN;
            next_go = 1'b1;
            next_dst = br1_t;
            next_pend = 1'b0;
          end
        default:
          next_state = seq_state;
      endcase
    end
    else if (step_done)
    begin
      if (term == `SES_T_IDLE)
        next_state = `SES_ST_IDLE;
      else if (term == `SES_T_HOLD)
      begin
        next_state = `SES_ST_HOLD;
        next_pend = 1'b1;
      end
      else if (end_seq)
        next_state = `SES_ST_IDLE;
      else
      begin
        next_go = 1'b1;
        next_dst = seq_next;
        next_jmp = take_jump;
      end
    end
  end

  // Sequencer registers; nothing moves until a start arrives
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      seq_state <= `SES_ST_IDLE;
      cur <= 8'h00;
      enter <= 1'b0;
      tick <= 32'd0;
      secs <= 16'd0;
      pend_adv <= 1'b0;
      jmp_step <= 8'h00;
      jmp_done <= 10'd0;
      jmp_spent <= 1'b0;
    end
    else
    begin
      seq_state <= next_state;
      pend_adv <= next_pend;
      enter <= next_go;
      if (next_state == `SES_ST_IDLE)
      begin
        cur <= 8'h00;
        jmp_step <= 8'h00;
        jmp_done <= 10'd0;
        jmp_spent <= 1'b0;
      end
      else if (next_go)
      begin
        cur <= next_dst;
        tick <= 32'd0;
        secs <= 16'd0;
        if (next_jmp && jmp_step == cur && !jmp_spent)
        begin
          if (jmp_done != 10'h3e7)
            jmp_done <= jmp_done + 10'd1;
        end
        else if (next_jmp)
        begin
          jmp_step <= cur;
          jmp_done <= 10'd1;
          jmp_spent <= 1'b0;
        end
        // Keep the tally for the query; a later visit loops again
        else if (jmp_step == cur)
          jmp_spent <= 1'b1;
      end
      else if (seq_state == `SES_ST_RUN && !enter)
      begin
        // Timer is frozen outside the run state
        if (tick >= UNIT_CYC - 32'd1)
        begin
          tick <= 32'd0;
          if (secs != 16'hffff)
            secs <= secs + 16'd1;
        end
        else
          tick <= tick + 32'd1;
      end
    end
  end

  // Sweep moves one count per tick; linear ramps would need a divider
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      swp_cnt <= 32'd0;
    else if (seq_state != `SES_ST_RUN || swp_cnt >= SWEEP_CYC - 32'd1)
      swp_cnt <= 32'd0;
    else
      swp_cnt <= swp_cnt + 32'd1;
  end
  wire swp_tick = seq_state == `SES_ST_RUN
                  && swp_cnt >= SWEEP_CYC - 32'd1;

  // DC level, AC amplitude and frequency share one layout
  genvar k;
  generate
    for (k = 0; k < 3; k = k + 1)
    begin : g_ch
      wire [31:0] cw = run_data[k*32 +: 32];
      reg  [19:0] val;
      reg  [19:0] tgt;
      reg         sw;
      always @(posedge sys_clk or negedge resetn)
      begin
        if (!resetn)
        begin
          val <= 20'h00000;
          tgt <= 20'h00000;
          sw <= 1'b0;
        end
        else if (enter && next_state != `SES_ST_IDLE)
        begin
          // Values are raw counts: 0.01 V/0.001 A, 0.1 Vpp/0.01 App, 0.1 Hz
          case (cw[`SES_F_OP])
            `SES_OP_CONST:
            begin
              val <= cw[`SES_F_VAL];
              sw <= 1'b0;
            end
            `SES_OP_SWEEP:
            begin
              tgt <= cw[`SES_F_VAL];
              sw <= 1'b1;
            end
            default:
              sw <= 1'b0;
          endcase
        end
        else if (swp_tick && sw)
        begin
          if ($signed(val) < $signed(tgt))
            val <= val + 20'h00001;
          else if ($signed(val) > $signed(tgt))
            val <= val - 20'h00001;
          else
            sw <= 1'b0;
        end
      end
    end
  endgenerate
  assign out_dc = g_ch[0].val;
  assign out_ac = g_ch[1].val;
  assign out_freq = g_ch[2].val;

  // Waveform and sync bits: constant or keep only
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      out_wave <= 5'd0;
      out_sync <= 2'b00;
    end
    else if (enter && next_state != `SES_ST_IDLE)
    begin
      if (!w_exp3[`SES_F_WOP])
        out_wave <= w_exp3[`SES_F_WAVE];
      if (!w_exp3[`SES_F_SOP])
        out_sync <= w_exp3[`SES_F_SYNC];
    end
  end
endmodule // ses_top

/* File: bench/ses_top_sva.sv */
`timescale 1ns/1ps
module ses_top_sva #(
  parameter [31:0] UNIT_CYC  = 32'h0000000a,
  parameter [31:0] SWEEP_CYC = 32'h00000002
) (
  // Clock and reset
  input wire        sys_clk,
  input wire        resetn,
  // Bus handshakes
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  // Sequencer outputs
  input wire [19:0] out_dc,
  input wire [1:0]  out_sync,
  input wire [1:0]  seq_state
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // Six quiet cycles so a command's late load is not mistaken for drift
  sequence held_quiet;
    (seq_state == 2'h2 && !s_axi_bvalid)[*6];
  endsequence

  state_code_a: assert property (seq_state != 2'h3)
    else $error("state code out of range");
  reset_idle_a: assert property ($rose(resetn) |->
    seq_state == 2'h0 && out_dc == 20'h00000 && out_sync == 2'h0)
    else $error("not idle after reset");
  idle_stays_a: assert property (
    seq_state == 2'h0 && !s_axi_bvalid |=> seq_state != 2'h1)
    else $error("ran without a start command");
  hold_frozen_a: assert property (held_quiet |->
    $stable(out_dc) && $stable(out_sync))
    else $error("set-points moved in hold");
  write_answer_a: assert property (wr_taken |-> ##2 s_axi_bvalid)
    else $error("write not answered");
  busy_refuse_a: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  read_answer_a: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read not answered");
  ready_pulse_a: assert property ($rose(s_axi_arready) |=>
    !s_axi_arready)
    else $error("read ready not a pulse");
endmodule // ses_top_sva

bind ses_top ses_top_sva #(.UNIT_CYC(UNIT_CYC), .SWEEP_CYC(SWEEP_CYC))
  i_sva (.sys_clk, .resetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .out_dc, .out_sync, .seq_state);

/* File: bench/ses_host.sv */
`timescale 1ns/1ps
module ses_host (
  // Clock
  input  wire         sys_clk,
  // Write side
  output logic [7:0]  s_axi_awaddr,
  output logic        s_axi_awvalid,
  input  wire         s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0]  s_axi_wstrb,
  output logic        s_axi_wvalid,
  input  wire         s_axi_wready,
  input  wire  [1:0]  s_axi_bresp,
  input  wire         s_axi_bvalid,
  output logic        s_axi_bready,
  // Read side
  output logic [7:0]  s_axi_araddr,
  output logic        s_axi_arvalid,
  input  wire         s_axi_arready,
  input  wire  [31:0] s_axi_rdata,
  input  wire  [1:0]  s_axi_rresp,
  input  wire         s_axi_rvalid,
  output logic        s_axi_rready
);
  initial
  begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
  end
  // Released lines show the inverse, never a stale copy
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    output logic [1:0] r);
    @(posedge sys_clk);
    {s_axi_awaddr, s_axi_wdata} <= {a, v};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    forever
    begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready)
        {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
      if (s_axi_wvalid && s_axi_wready)
        {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~v};
      if (s_axi_bvalid)
        break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v,
                    output logic [1:0] r);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    forever
    begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready)
        {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
      if (s_axi_rvalid)
        break;
    end
    {v, r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask
endmodule // ses_host

/* File: bench/ses_top_tb.sv */
`timescale 1ns/1ps
`include "ses_defines.vh"
module ses_top_tb;
  typedef struct packed {logic [7:0] a; logic [31:0] e; logic [1:0] r;}
    ses_row_t;
  logic        sys_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        wave_phase_zero = 1'b0;
  wire  [7:0]  s_axi_awaddr, s_axi_araddr;
  wire  [31:0] s_axi_wdata, s_axi_rdata;
  wire  [3:0]  s_axi_wstrb;
  wire  [1:0]  s_axi_bresp, s_axi_rresp, out_sync, seq_state;
  wire         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  wire         s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  wire         s_axi_rvalid, s_axi_rready;
  wire  [19:0] out_dc, out_ac, out_freq;
  wire  [4:0]  out_wave;
  integer      error_cnt = 0;
  integer      comparisons = 0;
  integer      cyc = 0;
  logic [31:0] d;
  logic [1:0]  r;
  ses_row_t    rows [7] = '{'{`SES_A_STAT, 32'h0, 2'h0},
    '{`SES_A_CUR, `SES_NONE, 2'h0}, '{`SES_A_JCNT, `SES_NONE, 2'h0},
    '{`SES_A_LEN, `SES_SEQ_LEN, 2'h0}, '{`SES_A_SEL, 32'h1, 2'h0},
    '{`SES_A_EXP0, 32'h0, 2'h0}, '{8'h40, 32'h0, 2'h2}};
  // Step words: select, then that step's fields
  logic [39:0] prog [16] = '{40'h0800000001, 40'h0c00003039,
    40'h1800002004, 40'h1c00000002, 40'h2400000400, 40'h0800000002,
    40'h0c00100000, 40'h1c00000001, 40'h2000000020, 40'h2400000003,
    40'h0800000003, 40'h1c00000001, 40'h2000020300, 40'h0800000004,
    40'h2000000011, 40'h0800000001};

  // Short counts keep a step second at ten cycles
  ses_top #(.UNIT_CYC(32'h0000000a), .SWEEP_CYC(32'h00000002)) i_dut (
    .sys_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .wave_phase_zero, .out_dc, .out_ac, .out_freq,
    .out_wave, .out_sync, .seq_state);
  ses_host i_host (.sys_clk, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end

  task check(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task w(input logic [7:0] a, input logic [31:0] v);
    i_host.wr(a, v, r);
    check("bresp", {30'h0, r}, 32'h0);
  endtask
  task rc(input string n, input logic [7:0] a, input logic [31:0] e);
    i_host.rd(a, d, r);
    check(n, d, e);
  endtask
  // Bounded poll: the step timer sets when the value shows
  task poll(input string n, input logic [7:0] a, input logic [31:0] e);
    repeat (100)
    begin
      i_host.rd(a, d, r);
      if (d === e)
        break;
    end
    check(n, d, e);
  endtask
  task report_and_stop;
    $display("Comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    foreach (rows[i])
    begin
      i_host.rd(rows[i].a, d, r);
      check("row data", d, rows[i].e);
      check("row resp", {30'h0, r}, {30'h0, rows[i].r});
    end
    i_host.wr(8'h3c, 32'h1, r);
    check("unmapped bresp", {30'h0, r}, 32'h2);
    $display("Test reset done");
    foreach (prog[i])
      w(prog[i][39:32], prog[i][31:0]);
    rc("dc word", `SES_A_EXP0, 32'h3039);
    w(`SES_A_CTRL, 32'h1);
    poll("cur step", `SES_A_CUR, 32'h1);
    check("dc", {12'h0, out_dc}, 32'h3039);
    check("sync", {30'h0, out_sync}, 32'h2);
    check("wave", {27'h0, out_wave}, 32'h4);
    poll("hold", `SES_A_STAT, 32'h2);
    rc("cur step", `SES_A_CUR, 32'h2);
    check("dc kept", {12'h0, out_dc}, 32'h3039);
    w(`SES_A_CTRL, 32'h3);
    poll("cur step", `SES_A_CUR, 32'h4);
    rc("state", `SES_A_STAT, 32'h1);
    w(`SES_A_SEL, 32'h3);
    rc("jumps", `SES_A_JCNT, 32'h2);
    repeat (30) @(posedge sys_clk);
    rc("phase wait", `SES_A_CUR, 32'h4);
    wave_phase_zero <= 1'b1;
    poll("idle", `SES_A_STAT, 32'h0);
    rc("cur idle", `SES_A_CUR, `SES_NONE);
    rc("jumps idle", `SES_A_JCNT, `SES_NONE);
    $display("Test flow done");
    w(`SES_A_CTRL, 32'h1);
    w(`SES_A_CTRL, 32'h2);
    poll("hold", `SES_A_STAT, 32'h2);
    repeat (40) @(posedge sys_clk);
    rc("frozen step", `SES_A_CUR, 32'h1);
    w(`SES_A_CTRL, 32'h4);
    poll("branch idle", `SES_A_STAT, 32'h0);
    w(`SES_A_CTRL, 32'h1);
    poll("cur step", `SES_A_CUR, 32'h1);
    w(`SES_A_CTRL, 32'h0);
    poll("stopped", `SES_A_STAT, 32'h0);
    rc("cur stop", `SES_A_CUR, `SES_NONE);
    $display("Test control done");
    w(`SES_A_SEL, 32'h2);
    w(`SES_A_MEM, 32'h0);
    rc("cleared dc", `SES_A_EXP0, 32'h0);
    rc("cleared br", `SES_A_TRP2, 32'h0);
    $display("Test clear done");
    w(`SES_A_SEL, 32'h1);
    w(8'h10, 32'h00200005);
    w(8'h14, 32'h00000003);
    w(8'h1c, 32'h00000002);
    w(8'h20, 32'h00000020);
    w(`SES_A_CTRL, 32'h1);
    poll("sweep hold", `SES_A_STAT, 32'h2);
    check("ac", {12'h0, out_ac}, 32'h5);
    check("freq", {12'h0, out_freq}, 32'h3);
    $display("Test sweep done");
    w(`SES_A_CTRL, 32'h1);
    resetn <= 1'b0;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    rc("state rst", `SES_A_STAT, 32'h0);
    rc("cur rst", `SES_A_CUR, `SES_NONE);
    $display("Test second reset done");
    report_and_stop();
  end
endmodule // ses_top_tb
